// *** logic/rcg_top.sv ***
// Reference clock generator: control register on AHB-Lite, a divider for the
// reference clock, a fixed divide-by-four for the clock-out function, and the
// registered pin and modulator outputs.
// Assumes configuration inputs and sleep come from logic on the system clock.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module rcg_top
  import rcg_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        sleep_i,
  input  wire logic        low_power_crystal_mode_i,
  input  wire logic        standard_crystal_mode_i,
  input  wire logic        high_speed_crystal_mode_i,
  input  wire logic        cpu_clock_out_n_i,
  output logic             refgen_output_pin_o,
  output logic             refgen_output_pin_oe_n_o,
  output logic             refgen_output_pin_bypass_o,
  output logic             refgen_slew_limit_o,
  output logic             modulator_clk_o,
  output logic             modulator_clk_bypass_o
);

  // Bus state.
  logic                  wr_pend_q;
  logic                  wr_pend_d;
  logic [RCG_OFS_W-1:0]  wr_addr_q;
  logic [RCG_OFS_W-1:0]  wr_addr_d;
  logic [31:0]           hrdata_q;
  logic [31:0]           hrdata_d;
  logic                  addr_take;
  logic [RCG_OFS_W-1:0]  addr_ofs;
  logic [RCG_CTRL_W-1:0] ctrl_view;
  logic [31:0]           status_word;

  // Control register.
  logic [RCG_CTRL_W-1:0] ctrl_q;
  logic [RCG_CTRL_W-1:0] ctrl_d;

  // Pin and modulator output registers.
  logic                  pin_q;
  logic                  pin_d;
  logic                  oe_n_q;
  logic                  oe_n_d;
  logic                  pin_byp_q;
  logic                  pin_byp_d;
  logic                  slew_q;
  logic                  slew_d;
  logic                  mod_q;
  logic                  mod_d;
  logic                  mod_byp_q;
  logic                  mod_byp_d;

  // Decoded configuration.
  logic                  gen_en;
  logic                  pin_drive;
  logic                  crystal;
  logic                  clkout_on;
  logic                  wdata_slew;

  rcg_div_if ref_if ();
  rcg_div_if co_if ();

  // Control fields and pin ownership.
  assign gen_en     = ctrl_q[RCG_EN_BIT];
  assign pin_drive  = ctrl_q[RCG_DRIVE_BIT];
  assign crystal    = low_power_crystal_mode_i | standard_crystal_mode_i
                      | high_speed_crystal_mode_i;
  assign clkout_on  = !cpu_clock_out_n_i;
  assign wdata_slew = hwdata_i[RCG_SLEW_BIT];

  // Reference divider steering. It is enabled by the control bit alone, so
  // a lost pin does not starve the modulator of its clock.
  assign ref_if.enable   = gen_en;
  assign ref_if.hold     = sleep_i;
  assign ref_if.div_sel  = ctrl_q[RCG_DIV_LSB +: 3];
  assign ref_if.duty_sel = ctrl_q[RCG_DUTY_LSB +: 2];

  // The clock-out divider is a fixed quarter of the system clock at half duty.
  assign co_if.enable    = clkout_on && !crystal;
  assign co_if.hold      = sleep_i;
  assign co_if.div_sel   = RCG_DIV_4;
  assign co_if.duty_sel  = RCG_DUTY_50;

  rcg_divider u_ref_div (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .div_if    (ref_if.gen)
  );

  rcg_divider u_co_div (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .div_if    (co_if.gen)
  );

  // Address phase decode; only the low byte of the address selects a register.
  assign addr_take = hsel_i && hready_i && htrans_i[RCG_HTRANS_ACT_BIT];
  assign addr_ofs  = haddr_i[RCG_OFS_W-1:0];

  // A read that directly follows a write to the control register sees the new
  // value, since the write lands on the same edge the read data is captured.
  assign ctrl_view = (wr_pend_q && wr_addr_q == RCG_CTRL_OFS)
                     ? hwdata_i[RCG_CTRL_W-1:0] : ctrl_q;

  // Status word reflects the live state of the generator and the pin.
  always_comb begin
    status_word                    = RCG_HRDATA_RESET;
    status_word[RCG_ST_RUN_BIT]    = gen_en && !sleep_i;
    status_word[RCG_ST_REFPIN_BIT] = !oe_n_q && !clkout_on && !crystal;
    status_word[RCG_ST_COPIN_BIT]  = !oe_n_q && clkout_on && !crystal;
    status_word[RCG_ST_XTAL_BIT]   = crystal;
    status_word[RCG_ST_LEVEL_BIT]  = ref_if.clk_level;
  end

  // Bus next state: zero wait states, always OKAY, unmapped reads give zero
  // and unmapped or narrow writes are dropped.
  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    hrdata_d  = hrdata_q;
    ctrl_d    = ctrl_q;
    if (wr_pend_q && wr_addr_q == RCG_CTRL_OFS) begin
      ctrl_d = hwdata_i[RCG_CTRL_W-1:0];
    end
    if (addr_take) begin
      if (hwrite_i) begin
        wr_pend_d = (hsize_i == RCG_HSIZE_WORD);
        wr_addr_d = addr_ofs;
      end else if (addr_ofs == RCG_CTRL_OFS) begin
        hrdata_d = {{(32-RCG_CTRL_W){1'b0}}, ctrl_view};
      end else if (addr_ofs == RCG_STATUS_OFS) begin
        hrdata_d = status_word;
      end else begin
        hrdata_d = RCG_HRDATA_RESET;
      end
    end
  end

  // Bus and control registers; reset restores the documented defaults.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= RCG_CTRL_OFS;
      hrdata_q  <= RCG_HRDATA_RESET;
      ctrl_q    <= RCG_CTRL_RESET;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q  <= hrdata_d;
      ctrl_q    <= ctrl_d;
    end
  end

  // Pin mux. A crystal owns the pin outright, then clock-out, then the
  // reference clock. The undivided case cannot be built from flip-flops, so
  // the pad is told to pass the system clock itself through the bypass flag.
  always_comb begin
    pin_d     = pin_q;
    oe_n_d    = oe_n_q;
    pin_byp_d = pin_byp_q;
    mod_d     = mod_q;
    mod_byp_d = mod_byp_q;
    slew_d    = ctrl_q[RCG_SLEW_BIT];
    if (!sleep_i) begin
      mod_d     = ref_if.clk_level;
      mod_byp_d = ref_if.bypass;
      if (crystal) begin
        pin_d     = 1'b0;
        oe_n_d    = 1'b1;
        pin_byp_d = 1'b0;
      end else if (clkout_on) begin
        pin_d     = co_if.clk_level;
        oe_n_d    = 1'b0;
        pin_byp_d = 1'b0;
      end else if (gen_en && pin_drive) begin
        pin_d     = ref_if.clk_level;
        oe_n_d    = 1'b0;
        pin_byp_d = ref_if.bypass;
      end else begin
        pin_d     = 1'b0;
        oe_n_d    = 1'b1;
        pin_byp_d = 1'b0;
      end
    end
  end

  // Output registers; the pin starts released after reset.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_q     <= 1'b0;
      oe_n_q    <= 1'b1;
      pin_byp_q <= 1'b0;
      slew_q    <= 1'b1;
      mod_q     <= 1'b0;
      mod_byp_q <= 1'b0;
    end else begin
      pin_q     <= pin_d;
      oe_n_q    <= oe_n_d;
      pin_byp_q <= pin_byp_d;
      slew_q    <= slew_d;
      mod_q     <= mod_d;
      mod_byp_q <= mod_byp_d;
    end
  end

  assign hrdata_o                   = hrdata_q;
  assign hreadyout_o                = 1'b1;
  assign hresp_o                    = 1'b0;
  assign refgen_output_pin_o        = pin_q;
  assign refgen_output_pin_oe_n_o   = oe_n_q;
  assign refgen_output_pin_bypass_o = pin_byp_q;
  assign refgen_slew_limit_o        = slew_q;
  assign modulator_clk_o            = mod_q;
  assign modulator_clk_bypass_o     = mod_byp_q;

  // Checks on the pin, the modulator feed and the control register.
  AST_RESET_DEFAULT: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> ctrl_q == RCG_CTRL_RESET && oe_n_q && !mod_q)
    else $error("Control not at default after reset");
  AST_CRYSTAL_NO_DRIVE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    crystal && !sleep_i |=> oe_n_q && !pin_byp_q) else $error("Pin driven in crystal mode");
  AST_CLKOUT_PRIO: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !crystal && clkout_on && !sleep_i |=> !oe_n_q && pin_q == $past(co_if.clk_level))
    else $error("Clock-out not on pin");
  AST_PIN_RELEASE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !crystal && !clkout_on && !sleep_i && !(gen_en && pin_drive) |=> oe_n_q && !pin_q)
    else $error("Pin driven without drive bit");
  AST_PIN_REF: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !crystal && !clkout_on && !sleep_i && gen_en && pin_drive
    |=> !oe_n_q && pin_q == $past(ref_if.clk_level)) else $error("Reference not on pin");
  AST_MOD_FEED: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !sleep_i |=> mod_q == $past(ref_if.clk_level) && mod_byp_q == $past(ref_if.bypass))
    else $error("Modulator clock not fed");
  AST_SLEEP_PIN: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sleep_i |=> $stable(pin_q) && $stable(oe_n_q) && $stable(mod_q))
    else $error("Outputs moved during sleep");
  AST_SLEW_WRITE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    wr_pend_q && wr_addr_q == RCG_CTRL_OFS ##1 !(wr_pend_q && wr_addr_q == RCG_CTRL_OFS)
    |=> refgen_slew_limit_o == $past(wdata_slew, 2)) else $error("Slew bit not applied");

endmodule : rcg_top

// *** logic/rcg_pkg.sv ***
// Constants, register map and field layout of the reference clock generator.
// Assumes a single 100 MHz system clock and an AHB-Lite bus with 32-bit data.
package rcg_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0]  RCG_CTRL_OFS       = 8'h00;
  localparam logic [7:0]  RCG_STATUS_OFS     = 8'h04;
  localparam int          RCG_OFS_W          = 8;

  // Control register layout and reset value.
  localparam int          RCG_CTRL_W         = 8;
  localparam int          RCG_EN_BIT         = 7;
  localparam int          RCG_DRIVE_BIT      = 6;
  localparam int          RCG_SLEW_BIT       = 5;
  localparam int          RCG_DUTY_LSB       = 3;
  localparam int          RCG_DIV_LSB        = 0;
  localparam logic [7:0]  RCG_CTRL_RESET     = 8'h30;

  // Status register layout.
  localparam int          RCG_ST_RUN_BIT     = 0;
  localparam int          RCG_ST_REFPIN_BIT  = 1;
  localparam int          RCG_ST_COPIN_BIT   = 2;
  localparam int          RCG_ST_XTAL_BIT    = 3;
  localparam int          RCG_ST_LEVEL_BIT   = 4;

  // Duty and divider codes.
  localparam logic [1:0]  RCG_DUTY_0         = 2'h0;
  localparam logic [1:0]  RCG_DUTY_25        = 2'h1;
  localparam logic [1:0]  RCG_DUTY_50        = 2'h2;
  localparam logic [1:0]  RCG_DUTY_75        = 2'h3;
  localparam logic [2:0]  RCG_DIV_BASE       = 3'h0;
  localparam logic [2:0]  RCG_DIV_2          = 3'h1;
  localparam logic [2:0]  RCG_DIV_4          = 3'h2;

  // Divider counter sizing.
  localparam int          RCG_CNT_W          = 7;
  localparam logic [6:0]  RCG_CNT_INIT       = 7'h7f;
  localparam logic [6:0]  RCG_CNT_STEP       = 7'h01;
  localparam logic [7:0]  RCG_PERIOD_UNIT    = 8'h01;

  // AHB-Lite encodings.
  localparam int          RCG_HTRANS_ACT_BIT = 1;
  localparam logic [2:0]  RCG_HSIZE_WORD     = 3'h2;
  localparam logic [31:0] RCG_HRDATA_RESET   = 32'h0000_0000;

endpackage : rcg_pkg

// *** logic/rcg_div_if.sv ***
// Interface between the top level and one divider/duty generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface rcg_div_if;
  logic       enable;
  logic       hold;
  logic [2:0] div_sel;
  logic [1:0] duty_sel;
  logic       clk_level;
  logic       bypass;

  // The top level steers the generator and reads back its waveform.
  modport ctrl (output enable, output hold, output div_sel, output duty_sel,
                input clk_level, input bypass);
  modport gen  (input enable, input hold, input div_sel, input duty_sel,
                output clk_level, output bypass);
endinterface : rcg_div_if

// *** logic/rcg_divider.sv ***
// Power-of-two divider with selectable duty, all outputs from flip-flops.
// Assumes the controller keeps configuration steady while checks run.
`timescale 1ns/1ns
module rcg_divider
  import rcg_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  rcg_div_if.gen    div_if
);

  logic [RCG_CNT_W-1:0] cnt_q;
  logic [RCG_CNT_W-1:0] cnt_d;
  logic                 out_q;
  logic                 out_d;
  logic                 byp_q;
  logic                 byp_d;
  logic [RCG_CNT_W:0]   period;
  logic [RCG_CNT_W:0]   mask;
  logic [RCG_CNT_W:0]   high;

  // Next count and level; one system clock is the finest step, so the
  // undivided and halved settings can only approximate the quarter duties.
  always_comb begin
    period = RCG_PERIOD_UNIT << div_if.div_sel;
    mask   = period - RCG_PERIOD_UNIT;
    unique case (div_if.duty_sel)
      RCG_DUTY_0:  high = '0;
      RCG_DUTY_25: high = period >> 2;
      RCG_DUTY_50: high = period >> 1;
      RCG_DUTY_75: high = (period >> 1) + (period >> 2);
    endcase
    if ((div_if.duty_sel != RCG_DUTY_0) && (high == '0)) begin
      high = RCG_PERIOD_UNIT;
    end
    cnt_d = cnt_q;
    out_d = out_q;
    byp_d = byp_q;
    if (!div_if.enable) begin
      cnt_d = mask[RCG_CNT_W-1:0];
      out_d = 1'b0;
      byp_d = 1'b0;
    end else if (!div_if.hold) begin
      cnt_d = (cnt_q + RCG_CNT_STEP) & mask[RCG_CNT_W-1:0];
      out_d = ({1'b0, cnt_d} < high);
      byp_d = (div_if.div_sel == RCG_DIV_BASE) && (div_if.duty_sel != RCG_DUTY_0);
    end
  end

  // Counter and waveform registers.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= RCG_CNT_INIT;
      out_q <= 1'b0;
      byp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      byp_q <= byp_d;
    end
  end

  assign div_if.clk_level = out_q;
  assign div_if.bypass    = byp_q;

  AST_DIS_LOW: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !div_if.enable |=> !out_q && !byp_q) else $error("Disabled divider not low");
  AST_FIRST_HIGH: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !div_if.enable ##1 (div_if.enable && !div_if.hold && div_if.duty_sel != RCG_DUTY_0)
    |=> out_q && cnt_q == '0) else $error("First period after enable not full");
  AST_DUTY0: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (div_if.duty_sel == RCG_DUTY_0)[*2] |=> !out_q && !byp_q) else $error("Zero duty not low");
  AST_HOLD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    div_if.enable && div_if.hold |=> $stable(out_q) && $stable(cnt_q))
    else $error("Divider moved during sleep");
  AST_WRAP4: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    div_if.enable && !div_if.hold && div_if.div_sel == RCG_DIV_4 && cnt_q == 7'h03
    |=> cnt_q == '0) else $error("Divide by four did not wrap");
  AST_Q25: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    div_if.enable && !div_if.hold && div_if.div_sel == 3'h4 && div_if.duty_sel == RCG_DUTY_25
    && cnt_q == 7'h03 |=> !out_q && cnt_q == 7'h04) else $error("Quarter duty wrong");
  AST_DIV2: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    div_if.enable && !div_if.hold && div_if.div_sel == RCG_DIV_2
    && div_if.duty_sel != RCG_DUTY_0 && cnt_q == 7'h01 |=> out_q)
    else $error("Halved clock missing high phase");
  AST_BYPASS: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    div_if.enable && !div_if.hold && div_if.div_sel == RCG_DIV_BASE
    && div_if.duty_sel != RCG_DUTY_0 |=> byp_q) else $error("Undivided mode not bypassed");

endmodule : rcg_divider

// *** tb/rcg_pad_model.sv ***
// Model of the far side: the shared pad and the modulator's clock input.
// Assumes the generator's outputs are registers on the system clock.
`timescale 1ns/1ns
module rcg_pad_model (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  input  wire logic pin_bypass_i,
  input  wire logic mod_clk_i,
  input  wire logic mod_bypass_i,
  output logic      pad_o,
  output logic      mod_lvl_o
);
  logic float_q;

  // A released pad has no pull, so it wanders; a stale value must never pass.
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      float_q <= 1'b0;
    end else begin
      float_q <= ~float_q;
    end
  end

  // The pad passes the raw clock in bypass, else the registered level.
  assign pad_o = (oe_n_i == 1'b0) ? (pin_bypass_i ? clock_i : pin_i) : float_q;
  // The modulator takes the divided clock or the raw system clock.
  assign mod_lvl_o = mod_bypass_i ? clock_i : mod_clk_i;
endmodule : rcg_pad_model

// *** tb/tb.sv ***
// Self-checking bench for the reference clock generator.
// Assumes the pad model beside the design and a zero-wait AHB-Lite slave.
`timescale 1ns/1ns
module tb;
  import rcg_pkg::*;
  logic        clock_i;
  logic        reset_n_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        sleep;
  logic [2:0]  xtal;
  logic        co_n;
  logic        pin, oe_n, pin_byp, slew, mod_clk, mod_byp, pad_lvl, mod_lvl;
  logic        msel;
  logic        rd_dp;
  logic [63:0] exp_q[$];
  int          mismatches, n_compared, hi, per, chg, d;
  wire         m_lvl = msel ? pad_lvl : mod_lvl;

  rcg_top u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .sleep_i(sleep), .low_power_crystal_mode_i(xtal[0]),
    .standard_crystal_mode_i(xtal[1]), .high_speed_crystal_mode_i(xtal[2]),
    .cpu_clock_out_n_i(co_n), .refgen_output_pin_o(pin), .refgen_output_pin_oe_n_o(oe_n),
    .refgen_output_pin_bypass_o(pin_byp), .refgen_slew_limit_o(slew),
    .modulator_clk_o(mod_clk), .modulator_clk_bypass_o(mod_byp));

  rcg_pad_model u_pad (.clock_i(clock_i), .reset_n_i(reset_n_i), .pin_i(pin),
    .oe_n_i(oe_n), .pin_bypass_i(pin_byp), .mod_clk_i(mod_clk),
    .mod_bypass_i(mod_byp), .pad_o(pad_lvl), .mod_lvl_o(mod_lvl));

  // Free-running system clock, 10 ns period.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Read data is taken at the edge that ends the data phase, oldest note first.
  always @(posedge clock_i) begin : mon
    logic [63:0] e;
    if (rd_dp && hready === 1'b1) begin
      e = exp_q.pop_front();
      check(hrdata & e[63:32], e[31:0]);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
    end
    rd_dp = reset_n_i && hsel && htrans[1] && !hwrite && hready;
  end

  // Address phase held until hready is seen high, then the data phase starts.
  task automatic bus_addr(input logic [7:0] a, input logic w);
    @(posedge clock_i);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= RCG_HSIZE_WORD;
    do @(posedge clock_i); while (hready !== 1'b1);
    htrans <= 2'b00;
  endtask : bus_addr

  task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
    bus_addr(a, 1'b1);
    hwdata <= v;
    do @(posedge clock_i); while (hready !== 1'b1);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus_addr(a, 1'b0);
    do @(posedge clock_i); while (hready !== 1'b1);
  endtask : bus_read

  // Write the control byte, read it back, and let the outputs settle.
  task automatic cfg(input logic [7:0] c);
    bus_write(RCG_CTRL_OFS, {24'h00_0000, c});
    bus_read(RCG_CTRL_OFS, {24'h00_0000, c}, 32'hFFFF_FFFF);
    repeat (2) @(negedge clock_i);
  endtask : cfg

  function automatic logic [7:0] cb(logic en, logic drv, logic sl, logic [1:0] dc, int dv);
    return {en, drv, sl, dc, dv[2:0]};
  endfunction : cb

  // High time per the duty code, at least one cycle for short periods.
  function automatic int exp_hi(input int dv, input int c);
    int h;
    h = ((1 << dv) * c) / 4;
    return (h == 0) ? 1 : h;
  endfunction : exp_hi

  // Measures the first whole period of the watched level; bounded waits.
  task automatic meas(output int h, output int p);
    int n;
    n = 0;
    h = 0;
    p = 0;
    while (m_lvl !== 1'b0 && n < 1000) begin @(negedge clock_i); n++; end
    while (m_lvl !== 1'b1 && n < 1000) begin @(negedge clock_i); n++; end
    while (m_lvl === 1'b1 && n < 1000) begin @(negedge clock_i); n++; h++; end
    p = h;
    while (m_lvl === 1'b0 && n < 1000) begin @(negedge clock_i); n++; p++; end
  endtask : meas

  // Counts level changes over a fixed span to prove a frozen or idle output.
  task automatic stay(output int c);
    logic l;
    c = 0;
    l = m_lvl;
    repeat (24) begin
      @(negedge clock_i);
      if (m_lvl !== l) c++;
    end
  endtask : stay

  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {sleep, xtal, msel, rd_dp, mismatches, n_compared} = '0;
    co_n = 1'b1;
    reset_n_i = 1'b0;
    void'($urandom(66));
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    bus_read(RCG_CTRL_OFS, 32'h0000_0030, 32'hFFFF_FFFF);
    check(slew, 1'b1);
    check(oe_n, 1'b1);
    bus_write(8'h08, 32'hFFFF_FFFF);
    bus_read(8'h08, 32'h0000_0000, 32'hFFFF_FFFF);
    bus_read(RCG_CTRL_OFS, 32'h0000_0030, 32'hFFFF_FFFF);
    bus_read(RCG_STATUS_OFS, 32'h0000_0000, 32'hFFFF_FFEF);
    // Divider codes 1 to 7 from a held counter: a whole period checked each time.
    for (d = 1; d < 8; d++) begin
      cfg(cb(1'b0, 1'b1, 1'b1, RCG_DUTY_50, d));
      cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_50, d));
      meas(hi, per);
      check(hi, exp_hi(d, 2));
      check(per, 1 << d);
    end
    // Quarter duties at divide-by-two and at a random longer divider.
    for (int c = 1; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        d = (k == 0) ? 1 : $urandom_range(2, 6);
        cfg(cb(1'b1, 1'b1, 1'b1, c[1:0], d));
        meas(hi, per);
        check(hi, exp_hi(d, c));
        check(per, 1 << d);
      end
    end
    cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_0, 3));
    stay(chg);
    check({chg[30:0], m_lvl}, 32'h0000_0000);
    cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_25, 0));
    check({pin_byp, mod_byp}, 2'b11);
    cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_0, 0));
    stay(chg);
    check({pin_byp, mod_byp, chg[29:0], m_lvl}, 32'h0000_0000);
    // Pin drive on and off; the modulator keeps its clock with the drive off.
    msel = 1'b1;
    cfg(cb(1'b1, 1'b1, 1'b0, RCG_DUTY_50, 2));
    check({slew, oe_n}, 2'b00);
    meas(hi, per);
    check({hi[15:0], per[15:0]}, 32'h0002_0004);
    bus_read(RCG_STATUS_OFS, 32'h0000_0003, 32'hFFFF_FFEF);
    msel = 1'b0;
    cfg(cb(1'b1, 1'b0, 1'b1, RCG_DUTY_50, 2));
    check({slew, oe_n}, 2'b11);
    meas(hi, per);
    check(per, 4);
    cfg(cb(1'b0, 1'b1, 1'b1, RCG_DUTY_50, 2));
    stay(chg);
    check({oe_n, chg[29:0], m_lvl}, 32'h8000_0000);
    // Each crystal mode takes the pin but leaves the modulator clock.
    for (int x = 0; x < 3; x++) begin
      xtal <= 3'b001 << x;
      cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_50, 2));
      check({oe_n, pin}, 2'b10);
      meas(hi, per);
      check(per, 4);
      bus_read(RCG_STATUS_OFS, 32'h0000_0009, 32'hFFFF_FFEF);
    end
    xtal <= 3'b000;
    // Clock-out wins the pin with a quarter-rate clock.
    co_n <= 1'b0;
    cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_50, 3));
    check(oe_n, 1'b0);
    msel = 1'b1;
    meas(hi, per);
    check({hi[15:0], per[15:0]}, 32'h0002_0004);
    msel = 1'b0;
    meas(hi, per);
    check(per, 8);
    bus_read(RCG_STATUS_OFS, 32'h0000_0005, 32'hFFFF_FFEF);
    co_n <= 1'b1;
    // Sleep freezes the output level, and the clock resumes on wake.
    cfg(cb(1'b1, 1'b1, 1'b1, RCG_DUTY_50, 3));
    repeat (5) @(posedge clock_i);
    sleep <= 1'b1;
    repeat (2) @(negedge clock_i);
    stay(chg);
    check(chg, 0);
    @(posedge clock_i);
    sleep <= 1'b0;
    meas(hi, per);
    check(per, 8);
    // A reset in mid-run restores the defaults and stops the output.
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    bus_read(RCG_CTRL_OFS, 32'h0000_0030, 32'hFFFF_FFFF);
    stay(chg);
    check({oe_n, chg[29:0], m_lvl}, 32'h8000_0000);
    end_of_test();
  end
endmodule : tb
